/* File: dde_pkg.sv */
// Purpose: shared constants for the directory entry decoder
// Assumes: 64-bit entries, APB register access
// Notes:   offsets are byte addresses of 32-bit words
package dde_pkg;
  // ----------------------------------------------------------------
  // entry field positions
  // ----------------------------------------------------------------
  localparam int PRESENT_POS   = 0;
  localparam int RW_POS        = 1;
  localparam int US_POS        = 2;
  localparam int WT_POS        = 3;
  localparam int CD_POS        = 4;
  localparam int ACC_POS       = 5;
  localparam int DIRTY_POS     = 6;
  localparam int PSIZE_POS     = 7;
  localparam int GLOBAL_POS    = 8;
  localparam int EXTU_POS      = 10;
  localparam int NOEXEC_POS    = 63;
  localparam int TBL_LSB       = 12;
  localparam int PAGE_LSB      = 21;
  localparam int HAW_DEFAULT   = 48;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ENTRY_LO_OFS = 8'h00;
  localparam logic [7:0] ENTRY_HI_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS     = 8'h08;
  localparam logic [7:0] STATUS_OFS   = 8'h0C;
  localparam logic [7:0] BASE_LO_OFS  = 8'h10;
  localparam logic [7:0] BASE_HI_OFS  = 8'h14;
  // ctrl register bits
  localparam int C_GLOBAL  = 0;
  localparam int C_WP      = 1;
  localparam int C_NX      = 2;
  localparam int C_EXTU    = 3;
  localparam int C_NEST    = 4;
  localparam int C_COHER   = 5;
  localparam int C_USER    = 6;
  localparam int C_WRITE   = 7;
  localparam int C_EXEC    = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage : dde_pkg

/* File: dde_decoder.sv */
// Purpose: decode a directory-level entry fetched by the page walker
// Assumes: APB slave, zero wait state, pclk 125 MHz
// Notes:   decode result is registered one cycle after any write
//
// Contract
// - bit7 set means 2-MByte page mapping
// - page mapping used only if present
// - global bit honoured when global enabled
// - bit6 is dirty flag of page
// - bit5 accessed flag in both formats
// - page memory type from bits4,3 if coherent
// - user request refused when bit2 clear
// - bit1 clear denies user, protected supervisor writes
// - table bit63 denies execute when enabled
// - table base bits HOST_ADDR_WIDTH-1:12, maybe guest
// - bit10 extended-used flag only when enabled
// - bit7 clear means table pointer
// - table followed only if present
// - table bits2,1 govern whole region
// - table fetch memory type bits4,3 if coherent
// - page base bits HOST_ADDR_WIDTH-1:21, maybe guest
// - page bit63 denies execute when enabled
`timescale 1ns/1ps
module dde_decoder
  import dde_pkg::*;
#(
  parameter int HOST_ADDR_WIDTH = HAW_DEFAULT
) (
  input  wire logic        pclk,        // bus clock
  input  wire logic        presetn,     // async reset, active low
  input  wire logic        pclken,      // clock enable, freezes state when low
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb access phase
  input  wire logic        pwrite,      // apb direction
  input  wire logic [7:0]  paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error, unmapped address
  output logic             walk_fault,  // entry absent, walk stops
  output logic             is_page,     // entry maps a 2-MByte page
  output logic             access_ok    // request allowed
);
  import dde_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [63:0] entry_r;
  logic [31:0] ctrl_r;
  logic [63:0] base_r;
  logic [15:0] status_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        fault_r;
  logic        page_r;
  logic        ok_r;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire setup_w   = psel & ~penable & pclken;
  wire hit_lo    = paddr == ENTRY_LO_OFS;
  wire hit_hi    = paddr == ENTRY_HI_OFS;
  wire hit_ctrl  = paddr == CTRL_OFS;
  wire hit_stat  = paddr == STATUS_OFS;
  wire hit_blo   = paddr == BASE_LO_OFS;
  wire hit_bhi   = paddr == BASE_HI_OFS;
  wire mapped_w  = hit_lo | hit_hi | hit_ctrl | hit_stat | hit_blo | hit_bhi;
  // writes land only at the access edge where ready is seen, never in setup
  wire wr_w      = psel & penable & pready_r & pclken & pwrite & mapped_w;

  // ----------------------------------------------------------------
  // entry decode
  // ----------------------------------------------------------------
  wire present_w = entry_r[PRESENT_POS];
  wire psize_w   = entry_r[PSIZE_POS];
  wire user_req  = ctrl_r[C_USER];
  wire wr_req    = ctrl_r[C_WRITE];
  wire ex_req    = ctrl_r[C_EXEC];
  wire coher_w   = ctrl_r[C_COHER];
  wire page_w    = psize_w;
  wire use_page  = page_w & present_w;
  wire follow_w  = ~page_w & present_w;
  wire fault_w   = ~present_w;
  wire global_w  = use_page & ctrl_r[C_GLOBAL] & entry_r[GLOBAL_POS];
  wire dirty_w   = use_page & entry_r[DIRTY_POS];
  wire acc_w     = present_w & entry_r[ACC_POS];
  wire extu_w    = present_w & ctrl_r[C_EXTU] & entry_r[EXTU_POS];
  // same bits, different target: page data vs table fetch
  wire [1:0] mtype_w = coher_w ? {entry_r[CD_POS], entry_r[WT_POS]} : 2'h0;
  // privilege bits apply to the page or the whole region alike
  wire us_deny   = user_req & ~entry_r[US_POS];
  wire wr_deny   = wr_req & ~entry_r[RW_POS] & (user_req | ctrl_r[C_WP]);
  wire nx_deny   = ex_req & ctrl_r[C_NX] & entry_r[NOEXEC_POS];
  wire ok_w      = present_w & ~us_deny & ~wr_deny & ~nx_deny;
  wire [63:0] tbl_base  = {{(64-HOST_ADDR_WIDTH){1'b0}}, entry_r[HOST_ADDR_WIDTH-1:TBL_LSB], 12'h000};
  wire [63:0] page_base = {{(64-HOST_ADDR_WIDTH){1'b0}}, entry_r[HOST_ADDR_WIDTH-1:PAGE_LSB], 21'h0};
  wire [63:0] base_w    = page_w ? page_base : tbl_base;
  wire        guest_w   = ctrl_r[C_NEST];
  wire [15:0] status_w  = {5'h00, guest_w, mtype_w, extu_w, acc_w, dirty_w,
                           global_w, follow_w, use_page, ok_w, fault_w};

  wire [31:0] rd_w = hit_lo   ? entry_r[31:0]  :
                     hit_hi   ? entry_r[63:32] :
                     hit_ctrl ? ctrl_r         :
                     hit_stat ? {16'h0000, status_r} :
                     hit_blo  ? base_r[31:0]   :
                     hit_bhi  ? base_r[63:32]  : 32'h0000_0000;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      entry_r <= 64'h0;
      ctrl_r  <= CTRL_RESET;
    end
    else if (wr_w)
    begin
      if (hit_lo)   entry_r[31:0]  <= pwdata;
      if (hit_hi)   entry_r[63:32] <= pwdata;
      if (hit_ctrl) ctrl_r         <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_r <= 16'h0000;
      base_r   <= 64'h0;
      fault_r  <= 1'b0;
      page_r   <= 1'b0;
      ok_r     <= 1'b0;
    end
    else if (pclken)
    begin
      status_r <= status_w;
      base_r   <= base_w;
      fault_r  <= fault_w;
      page_r   <= use_page;
      ok_r     <= ok_w;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else if (pclken)
    begin
      pready_r  <= setup_w;
      pslverr_r <= setup_w & ~mapped_w;
      prdata_r  <= (setup_w & ~pwrite) ? rd_w : 32'h0000_0000;
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign walk_fault = fault_r;
  assign is_page    = page_r;
  assign access_ok  = ok_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  absent_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && !entry_r[PRESENT_POS] |=> walk_fault && !access_ok)
    else $error("absent entry without fault");
  page_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken |=> is_page == $past(entry_r[PSIZE_POS] & entry_r[PRESENT_POS]))
    else $error("page mapping decode wrong");
  user_deny_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && ctrl_r[C_USER] && !entry_r[US_POS] |=> !access_ok)
    else $error("user request not refused");
  write_deny_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && ctrl_r[C_WRITE] && !entry_r[RW_POS] && ctrl_r[C_WP] |=> !access_ok)
    else $error("protected write allowed");
  exec_deny_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && ctrl_r[C_EXEC] && ctrl_r[C_NX] && entry_r[NOEXEC_POS] |=> !access_ok)
    else $error("execute allowed on no-exec entry");
  table_base_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && !entry_r[PSIZE_POS] |=> base_r[11:0] == 12'h000)
    else $error("table base not aligned");
  page_base_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && entry_r[PSIZE_POS] |=> base_r[20:0] == 21'h0)
    else $error("page base not aligned");
  ext_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && !ctrl_r[C_EXTU] |=> !status_r[7])
    else $error("extended flag seen while disabled");
  mtype_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && !ctrl_r[C_COHER] |=> status_r[9:8] == 2'h0)
    else $error("memory type bits used for non-coherent");
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && pclken |=> pready)
    else $error("apb access not answered");

  // ----------------------------------------------------------------
  // entry format checks
  // ----------------------------------------------------------------
  present_use_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && !entry_r[PRESENT_POS]
    |=> !is_page)
    else $error("absent page entry used");
  table_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && (entry_r[PSIZE_POS] || !entry_r[PRESENT_POS])
    |=> !status_r[3])
    else $error("table followed wrongly");
  table_kind_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && entry_r[PRESENT_POS] && !entry_r[PSIZE_POS]
    |=> status_r[3] && !is_page)
    else $error("table entry not followed");
  global_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && ctrl_r[C_GLOBAL] && entry_r[GLOBAL_POS] && entry_r[PSIZE_POS] && entry_r[0]
    |=> status_r[4])
    else $error("global page not honoured");
  global_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && !ctrl_r[C_GLOBAL]
    |=> !status_r[4])
    else $error("global seen while disabled");
  dirty_page_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && !entry_r[PSIZE_POS]
    |=> !status_r[5])
    else $error("dirty seen on table entry");
  dirty_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && entry_r[PRESENT_POS] && entry_r[PSIZE_POS] && entry_r[DIRTY_POS]
    |=> status_r[5])
    else $error("dirty page not reported");
  accessed_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && entry_r[PRESENT_POS] && entry_r[PSIZE_POS]
    |=> status_r[6] == $past(entry_r[ACC_POS]))
    else $error("page accessed flag wrong");
  accessed_table_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && entry_r[PRESENT_POS] && !entry_r[PSIZE_POS]
    |=> status_r[6] == $past(entry_r[ACC_POS]))
    else $error("table accessed flag wrong");
  ext_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && ctrl_r[C_EXTU] && entry_r[PRESENT_POS]
    |=> status_r[7] == $past(entry_r[EXTU_POS]))
    else $error("extended flag lost");
  mtype_coher_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && ctrl_r[C_COHER] && entry_r[PSIZE_POS]
    |=> status_r[9:8] == $past({entry_r[CD_POS], entry_r[WT_POS]}))
    else $error("page memory type wrong");
  table_mtype_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && ctrl_r[C_COHER] && !entry_r[PSIZE_POS]
    |=> status_r[9:8] == $past({entry_r[CD_POS], entry_r[WT_POS]}))
    else $error("table memory type wrong");

  // ----------------------------------------------------------------
  // permission checks
  // ----------------------------------------------------------------
  region_user_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && !entry_r[PSIZE_POS] && ctrl_r[C_USER] && !entry_r[US_POS]
    |=> !access_ok)
    else $error("user allowed in region");
  user_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && ctrl_r[C_WRITE] && ctrl_r[C_USER] && !entry_r[RW_POS]
    |=> !access_ok)
    else $error("user write allowed");
  table_exec_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && !entry_r[PSIZE_POS] && ctrl_r[C_EXEC] && ctrl_r[C_NX] && entry_r[NOEXEC_POS]
    |=> !access_ok)
    else $error("execute allowed in region");
  plain_grant_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && entry_r[PRESENT_POS] && !ctrl_r[C_USER] && !ctrl_r[C_WRITE] && !ctrl_r[C_EXEC]
    |=> access_ok)
    else $error("plain request refused");
  sup_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && entry_r[0] && !ctrl_r[C_USER] && ctrl_r[C_WRITE] && !ctrl_r[C_WP] && !ctrl_r[C_EXEC]
    |=> access_ok)
    else $error("supervisor write refused");
  exec_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && entry_r[0] && !ctrl_r[C_USER] && !ctrl_r[C_WRITE] && ctrl_r[C_EXEC] && !ctrl_r[C_NX]
    |=> access_ok)
    else $error("execute refused while disabled");

  // ----------------------------------------------------------------
  // base and guest checks
  // ----------------------------------------------------------------
  table_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && !entry_r[PSIZE_POS]
    |=> base_r[HOST_ADDR_WIDTH-1:TBL_LSB] == $past(entry_r[HOST_ADDR_WIDTH-1:TBL_LSB]))
    else $error("table base wrong");
  page_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && entry_r[PSIZE_POS]
    |=> base_r[HOST_ADDR_WIDTH-1:PAGE_LSB] == $past(entry_r[HOST_ADDR_WIDTH-1:PAGE_LSB]))
    else $error("page base wrong");
  upper_base_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken
    |=> base_r[63:HOST_ADDR_WIDTH] == '0)
    else $error("base above address width");
  guest_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken
    |=> status_r[10] == $past(ctrl_r[C_NEST]))
    else $error("guest marking wrong");

  // ----------------------------------------------------------------
  // bus checks
  // ----------------------------------------------------------------
  apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && pclken && !mapped_w
    |=> pslverr && pready)
    else $error("unmapped access not flagged");
  apb_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && pready
    |=> !pready)
    else $error("ready held too long");
  rd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && !(psel && !penable && !pwrite)
    |=> prdata == 32'h0000_0000)
    else $error("read data outside access");
  read_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && psel && !penable && !pwrite && paddr == CTRL_OFS
    |=> prdata == $past(ctrl_r))
    else $error("ctrl read data wrong");
  write_lands_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && psel && penable && pready && pwrite && paddr == CTRL_OFS
    |=> ctrl_r == $past(pwdata))
    else $error("ctrl write lost");
  entry_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && psel && penable && pready && pwrite && paddr == ENTRY_LO_OFS
    |=> entry_r[31:0] == $past(pwdata))
    else $error("entry write lost");
  no_early_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && psel && !penable && pwrite
    |=> $stable(ctrl_r) && $stable(entry_r))
    else $error("write landed in setup");
  unmapped_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclken && psel && penable && pwrite && !mapped_w
    |=> $stable(ctrl_r) && $stable(entry_r))
    else $error("unmapped write landed");
endmodule : dde_decoder

/* File: dde_walker.sv */
// Purpose: page walker model, hands fetched entries to the decoder
// Assumes: apb slave answers in bounded time
// Notes:   released address and data lines show inverted values, never the last ones
`timescale 1ns/1ps
module dde_walker (
  input  wire logic        pclk,    // bus clock
  input  wire logic        pready,  // slave ready
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pslverr, // slave error
  output logic             psel,    // select
  output logic             penable, // access phase
  output logic             pwrite,  // direction
  output logic      [7:0]  paddr,   // byte address
  output logic      [31:0] pwdata   // write data
);
  // ----------------------------------------------------------------
  // apb transfer
  // ----------------------------------------------------------------
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
endmodule : dde_walker

/* File: testbench.sv */
// Purpose: random and corner checks of the entry decoder
// Assumes: clock enable held high throughout
// Notes:   expectations come from the entry and ctrl bits alone
`timescale 1ns/1ps
module testbench;
  import dde_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic        walk_fault, is_page, access_ok, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, seed;
  logic [63:0] e, m;
  logic [8:0]  c;
  logic [3:0]  x;
  int          fail_count = 0;
  int          compares = 0;
  always #4 pclk = ~pclk;
  dde_walker WLK (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  dde_decoder #(.HOST_ADDR_WIDTH(HAW_DEFAULT)) DUT (.pclk(pclk), .presetn(presetn), .pclken(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .walk_fault(walk_fault),
    .is_page(is_page), .access_ok(access_ok));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // {table followed, page used, allowed, fault}
  function automatic logic [3:0] want(input logic [63:0] v, input logic [8:0] k);
    logic deny;
    deny = (k[C_USER] & ~v[US_POS]) | (k[C_WRITE] & ~v[RW_POS] & (k[C_USER] | k[C_WP]))
         | (k[C_EXEC] & k[C_NX] & v[NOEXEC_POS]);
    return {v[0] & ~v[7], v[0] & v[7], v[0] & ~deny, ~v[0]};
  endfunction : want
  // {guest, memory type, extended used, accessed, dirty, global}
  function automatic logic [6:0] flags(input logic [63:0] v, input logic [8:0] k);
    return {k[C_NEST], k[C_COHER] ? {v[CD_POS], v[WT_POS]} : 2'h0,
            v[0] & k[C_EXTU] & v[EXTU_POS], v[0] & v[ACC_POS],
            v[0] & v[7] & v[DIRTY_POS], v[0] & v[7] & k[C_GLOBAL] & v[GLOBAL_POS]};
  endfunction : flags
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string s);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, s);
    end
  endtask : check
  task automatic finish_test();
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial
  begin
    seed = 32'h1ABCE7E4;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check({31'h0, walk_fault}, 32'h1, "fault after reset");
    WLK.xfer(1'b0, CTRL_OFS, 32'h0, q, er);
    check(q, CTRL_RESET, "ctrl reset");
    WLK.xfer(1'b0, 8'h18, 32'h0, q, er);
    check({q[30:0], er}, 32'h1, "unmapped read");
    $display("test reset and unmapped done");
    for (int i = 0; i < 64; i++)
    begin
      e = {rnd(), rnd()};
      c = rnd();
      // the first passes force each entry kind with every request bit
      if (i < 4)
        e[7:0] = {i[0], 6'h0, i[1]};
      if (i < 4)
        c = 9'h1FF;
      WLK.xfer(1'b1, ENTRY_LO_OFS, e[31:0], q, er);
      WLK.xfer(1'b1, ENTRY_HI_OFS, e[63:32], q, er);
      WLK.xfer(1'b1, CTRL_OFS, {23'h0, c}, q, er);
      repeat (2) @(posedge pclk);
      x = want(e, c);
      check({31'h0, walk_fault}, {31'h0, x[0]}, "fault");
      check({31'h0, is_page}, {31'h0, x[2]}, "page");
      check({31'h0, access_ok}, {31'h0, x[1]}, "access");
      WLK.xfer(1'b0, STATUS_OFS, 32'h0, q, er);
      check({28'h0, q[3:0]}, {28'h0, x}, "status");
      check({25'h0, q[10:4]}, {25'h0, flags(e, c)}, "status flags");
      check({31'h0, er}, 32'h0, "status error");
      m = ((64'h1 << HAW_DEFAULT) - 1) & ~((64'h1 << (e[7] ? PAGE_LSB : TBL_LSB)) - 1);
      WLK.xfer(1'b0, BASE_LO_OFS, 32'h0, q, er);
      check(q, e[31:0] & m[31:0], "base lo");
      WLK.xfer(1'b0, BASE_HI_OFS, 32'h0, q, er);
      check(q, e[63:32] & m[63:32], "base hi");
    end
    $display("test random entries done");
    finish_test();
  end
endmodule : testbench
